// ### hdl/ana_axil_slave.sv
// axi4-lite slave front end: turns bus transfers into register requests
// assumes rd_data and the error flags answer the request address combinationally
`timescale 1ns/1ps
`default_nettype none
module ana_axil_slave import ana_pkg::*; (
  // clock, reset, accept enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en,
  // write address and data
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [ANA_AW-1:0] s_awaddr,
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  // write response
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  // read address and data
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [ANA_AW-1:0] s_araddr,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  // register file side
  output ana_req_t req,
  input wire logic [15:0] rd_data,
  input wire logic rd_err,
  input wire logic wr_err
);
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [ANA_AW-1:0] awaddr_q, awaddr_d;
  logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [1:0] wstrb_q, wstrb_d, bresp_q, bresp_d, rresp_q, rresp_d;
  logic ar_hs, do_wr;

  assign s_awready = en & ~aw_full_q;
  assign s_wready = en & ~w_full_q;
  assign s_arready = en & ~rvalid_q;
  assign ar_hs = s_arvalid & s_arready;
  // write fires once both halves are held and the last response is gone
  assign do_wr = aw_full_q & w_full_q & ~bvalid_q;
  assign req = '{wr: do_wr, rd: ar_hs, waddr: awaddr_q, raddr: s_araddr,
                 wdata: wdata_q, wstrb: wstrb_q};

  // next-state for both channels
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q & ~s_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q & ~s_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_awvalid && s_awready) begin
      aw_full_d = 1'b1;
      awaddr_d = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_full_d = 1'b1;
      wdata_d = s_wdata[15:0];
      wstrb_d = s_wstrb[1:0];
    end
    if (do_wr) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_err ? ANA_RESP_SLVERR : ANA_RESP_OKAY;
    end
    if (ar_hs) begin
      rvalid_d = 1'b1;
      rdata_d = rd_err ? 16'h0000 : rd_data;
      rresp_d = rd_err ? ANA_RESP_SLVERR : ANA_RESP_OKAY;
    end
  end

  // channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= ANA_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= ANA_RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_rvalid = rvalid_q;
  assign s_rdata = {16'h0000, rdata_q};
  assign s_rresp = rresp_q;
endmodule
`default_nettype wire

// ### hdl/ana_regs.sv
// auto-negotiation advertisement, partner ability and page-received flag
// assumes negotiation logic on aclk delivers partner pages as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Bit 15 of the advertisement is read/write, claims multi-page ability and resets to zero.
// - Bit 10 advertises full-duplex pause and bit 11 asymmetric pause, both read/write, bit 11 resetting to zero.
// - The pause bit takes its reset value from its own strap pin.
// - The T4 bit 9 may be set by software and is advertised as written, resetting to zero.
// - Bits 8 to 5 advertise 100TX full, 100TX, 10T full and 10T, all read/write.
// - Those four ability bits load their reset values from the configuration straps.
// - Bits 4 to 0 hold a read/write selector resetting to 00001, with 00010 the isdn-lan code and 00000, 11111 reserved.
// - Bit 13 is a read/write remote fault locally, reset zero, and read-only partner fault in the partner word.
// - The partner base page is read-only and resets to zero, its bit 15 the partner multi-page ability.
// - Partner bit 14 shows whether the partner acknowledged our code word.
// - Partner abilities T4 and the four technologies read back on bits 9 to 5.
// - Partner pause and asymmetric pause read back on bits 10 and 11.
// - The partner selector reads back on bits 4 to 0 with the local encoding.
// - Loading a partner page sets the latching page-received flag, bit 1 of the expansion word, cleared on read.
module ana_regs import ana_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [ANA_AW-1:0] s_awaddr,
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  // axi4-lite read channels
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [ANA_AW-1:0] s_araddr,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  // strap pins
  input wire logic [3:0] config_strap_pins,
  input wire logic pause_strap,
  // negotiation logic side
  input wire logic lp_page_valid,
  input wire ana_word_t lp_page_word,
  output ana_word_t adv_word,
  output logic page_received
);
  ana_req_t req;
  ana_word_t adv_q, adv_d, lp_q, lp_d, adv_wr;
  ana_state_t st_q, st_d;
  logic [2:0] settle_q, settle_d;
  logic page_rx_q, page_rx_d;
  logic [3:0] tech_lvl;
  logic pause_lvl;
  logic [15:0] rd_data;
  logic rd_err, wr_err, wr_adv, rd_exp;

  // strap synchronisers
  ana_sync3 #(.W(4)) u_sync_tech (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(config_strap_pins),
    .level(tech_lvl)
  );
  ana_sync3 #(.W(1)) u_sync_pause (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(pause_strap),
    .level(pause_lvl)
  );

  // bus front end, held off until the straps are loaded
  ana_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(st_q == ANA_ST_RUN),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_awaddr(s_awaddr),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_bresp(s_bresp),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_araddr(s_araddr),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .req(req),
    .rd_data(rd_data),
    .rd_err(rd_err),
    .wr_err(wr_err)
  );

  // address decode
  assign wr_adv = req.wr && (req.waddr == ANA_ADDR_ADV);
  assign rd_exp = req.rd && (req.raddr == ANA_ADDR_EXP);
  assign wr_err = !(req.waddr inside {ANA_ADDR_ADV, ANA_ADDR_LP, ANA_ADDR_EXP});
  assign rd_err = !(req.raddr inside {ANA_ADDR_ADV, ANA_ADDR_LP, ANA_ADDR_EXP});

  // read mux; reserved bits forced low
  always_comb begin
    rd_data = 16'h0000;
    unique case (req.raddr)
      ANA_ADDR_ADV: begin
        rd_data = adv_q;
      end
      ANA_ADDR_LP: begin
        rd_data = lp_q;
      end
      ANA_ADDR_EXP: begin
        rd_data[ANA_BIT_PAGE_RX] = page_rx_q;
      end
      default: begin
        rd_data = 16'h0000;
      end
    endcase
    rd_data[ANA_BIT_RSVD12] = 1'b0;
    if (req.raddr == ANA_ADDR_ADV) begin
      rd_data[ANA_BIT_RSVD14] = 1'b0;
    end
  end

  // byte-lane merge of a write into the advertisement
  always_comb begin
    adv_wr = adv_q;
    if (req.wstrb[0]) begin
      adv_wr[7:0] = req.wdata[7:0];
    end
    if (req.wstrb[1]) begin
      adv_wr[15:8] = req.wdata[15:8];
    end
    adv_wr.ack = 1'b0;
    adv_wr.rsvd12 = 1'b0;
  end

  // strap loader and advertisement next state
  always_comb begin
    st_d = st_q;
    settle_d = settle_q;
    adv_d = adv_q;
    unique case (st_q)
      ANA_ST_SETTLE: begin
        settle_d = settle_q + 3'h1;
        if (settle_q == ANA_STRAP_SETTLE) begin
          st_d = ANA_ST_RUN;
          adv_d.pause = pause_lvl;
          {adv_d.tx_fd, adv_d.tx_hd, adv_d.t10_fd, adv_d.t10_hd} = tech_lvl;
        end
      end
      ANA_ST_RUN: begin
        if (wr_adv) begin
          adv_d = adv_wr; // selector stored as written
        end
      end
      default: begin
        st_d = ANA_ST_SETTLE;
      end
    endcase
  end

  // partner page and latching flag next state; a set beats a read clear
  always_comb begin
    lp_d = lp_q;
    page_rx_d = page_rx_q;
    if (rd_exp) begin
      page_rx_d = 1'b0;
    end
    if (lp_page_valid) begin
      lp_d = lp_page_word;
      lp_d.rsvd12 = 1'b0;
      page_rx_d = 1'b1;
    end
  end

  // state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ANA_ST_SETTLE;
      settle_q <= 3'h0;
      adv_q <= ANA_ADV_RST;
      lp_q <= '0;
      page_rx_q <= 1'b0;
    end else begin
      st_q <= st_d;
      settle_q <= settle_d;
      adv_q <= adv_d;
      lp_q <= lp_d;
      page_rx_q <= page_rx_d;
    end
  end

  assign adv_word = adv_q;
  assign page_received = page_rx_q;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_np_reset:
  assert property ($rose(aresetn) |-> !adv_q.next_page && !adv_q.asym_pause && !adv_q.t4)
    else $error("advertisement high bits not cleared by reset");
  a_sel_reset:
  assert property ($rose(aresetn) |-> adv_q.selector == ANA_SEL_8023)
    else $error("selector reset value wrong");
  a_pause_strap:
  assert property ($rose(st_q == ANA_ST_RUN) |-> adv_q.pause == $past(pause_lvl))
    else $error("pause bit not loaded from strap");
  a_tech_strap:
  assert property ($rose(st_q == ANA_ST_RUN) |->
                   {adv_q.tx_fd, adv_q.tx_hd, adv_q.t10_fd, adv_q.t10_hd} == $past(tech_lvl))
    else $error("ability bits not loaded from straps");
  a_settle_time:
  assert property ($rose(aresetn) |-> (st_q == ANA_ST_SETTLE)[*6] ##1 st_q == ANA_ST_RUN)
    else $error("strap load not at settle count");
  a_high_write:
  assert property (wr_adv && req.wstrb[1] && st_q == ANA_ST_RUN |=>
                   adv_q.t4 == $past(req.wdata[9]) && adv_q.next_page == $past(req.wdata[15])
                   && adv_q.remote_fault == $past(req.wdata[13]) && !adv_q.ack)
    else $error("upper advertisement write not stored");
  a_low_write:
  assert property (wr_adv && req.wstrb[0] && st_q == ANA_ST_RUN |=>
                   adv_q[7:0] == $past(req.wdata[7:0]))
    else $error("lower advertisement write not stored");
  a_rsvd_zero:
  assert property (req.rd && req.raddr == ANA_ADDR_ADV |-> !rd_data[14] && !rd_data[12])
    else $error("reserved advertisement bits read nonzero");
  a_lp_load:
  assert property (lp_page_valid |=> lp_q[15:13] == $past(lp_page_word[15:13])
                   && lp_q[11:0] == $past(lp_page_word[11:0]))
    else $error("partner page not captured");
  a_lp_ack_read:
  assert property (req.rd && req.raddr == ANA_ADDR_LP |-> rd_data[14] == lp_q.ack && !rd_data[12])
    else $error("partner acknowledge not visible");
  a_flag_set:
  assert property (lp_page_valid |=> page_rx_q)
    else $error("page-received flag not set");
  a_flag_clear:
  assert property (rd_exp && !lp_page_valid |-> rd_data[ANA_BIT_PAGE_RX] == page_rx_q ##1 !page_rx_q)
    else $error("page-received flag not cleared on read");

  // loader, lane merge, hold and read-back checks
  a_pause_write:
  assert property (wr_adv && req.wstrb[1] |=> adv_q.pause == $past(req.wdata[10])
                   && adv_q.asym_pause == $past(req.wdata[11]))
    else $error("pause bits not stored on write");
  a_rsvd_write:
  assert property (wr_adv |=> !adv_q.ack && !adv_q.rsvd12)
    else $error("reserved advertisement bits stored");
  a_sel_write:
  assert property (wr_adv && req.wstrb[0] |=> adv_q.selector == $past(req.wdata[4:0]))
    else $error("selector not stored as written");
  a_high_keep:
  assert property (wr_adv && !req.wstrb[1] |=> adv_q[15:8] == $past(adv_q[15:8]))
    else $error("upper advertisement byte changed without its lane");
  a_low_keep:
  assert property (wr_adv && !req.wstrb[0] |=> adv_q[7:0] == $past(adv_q[7:0]))
    else $error("lower advertisement byte changed without its lane");
  a_adv_hold:
  assert property (st_q == ANA_ST_RUN && !wr_adv |=> $stable(adv_q))
    else $error("advertisement changed without a write");
  a_no_req_settle:
  assert property (st_q == ANA_ST_SETTLE |-> !req.wr && !req.rd)
    else $error("bus request taken before straps loaded");
  a_pause_settle:
  assert property (st_q == ANA_ST_SETTLE |-> adv_q[10:5] == 6'h00)
    else $error("strap bits set before load");
  a_settle_count:
  assert property (st_q == ANA_ST_SETTLE |-> settle_q <= ANA_STRAP_SETTLE)
    else $error("settle counter overran");
  a_run_stays:
  assert property (st_q == ANA_ST_RUN |=> st_q == ANA_ST_RUN)
    else $error("strap loader left run state");
  a_lp_hold:
  assert property (!lp_page_valid |=> $stable(lp_q))
    else $error("partner word changed without a page");
  a_lp_rsvd:
  assert property (!lp_q.rsvd12)
    else $error("partner reserved bit set");
  a_lp_read:
  assert property (req.rd && req.raddr == ANA_ADDR_LP |-> rd_data[11:0] == lp_q[11:0]
                   && rd_data[15:13] == lp_q[15:13])
    else $error("partner word not returned on read");
  a_exp_read:
  assert property (req.rd && req.raddr == ANA_ADDR_EXP |-> rd_data == {14'h0000, page_rx_q, 1'b0})
    else $error("expansion word read wrong");
  a_flag_hold:
  assert property (!lp_page_valid && !rd_exp |=> $stable(page_rx_q))
    else $error("page-received flag changed without cause");
  a_set_wins:
  assert property (lp_page_valid && rd_exp |=> page_rx_q)
    else $error("read clear beat a page arrival");

  c_page_then_read: cover property (lp_page_valid ##[1:50] rd_exp);
  c_adv_write: cover property (wr_adv && req.wstrb == 2'h3);
  c_strap_load: cover property ($rose(st_q == ANA_ST_RUN) && adv_q.pause);
  c_set_clear_same: cover property (lp_page_valid && rd_exp);
  c_restrap: cover property ($rose(st_q == ANA_ST_RUN) && !adv_q.pause);
endmodule
`default_nettype wire

// ### hdl/ana_sync3.sv
// three-stage synchroniser with agreement filter for slow strap pins
// assumes the pins are static or slow compared with aclk
`timescale 1ns/1ps
`default_nettype none
module ana_sync3 import ana_pkg::*; #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins and filtered result
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q, s2_q, s3_q, level_q, level_d;

  // next filtered level: take it once stages two and three agree
  always_comb begin
    level_d = level_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        level_d[i] = s3_q[i];
      end
    end
  end

  // stage registers; only stage two reads stage one
  always_ff @(posedge aclk) begin
    s1_q <= pin;
    s2_q <= s1_q;
    s3_q <= s2_q;
    level_q <= aresetn ? level_d : '0;
  end

  assign level = level_q;
endmodule
`default_nettype wire

// ### inc/ana_pkg.sv
// auto-negotiation ability register constants, layouts and bus types
// assumes a 32-bit axi4-lite slave with byte addresses = 4 * register index
package ana_pkg;
  // register indices and byte addresses
  localparam int ANA_AW = 8;
  localparam logic [ANA_AW-1:0] ANA_IDX_ADV = 8'h04;
  localparam logic [ANA_AW-1:0] ANA_IDX_LP = 8'h05;
  localparam logic [ANA_AW-1:0] ANA_IDX_EXP = 8'h06;
  localparam logic [ANA_AW-1:0] ANA_ADDR_ADV = {ANA_IDX_ADV[5:0], 2'b00};
  localparam logic [ANA_AW-1:0] ANA_ADDR_LP = {ANA_IDX_LP[5:0], 2'b00};
  localparam logic [ANA_AW-1:0] ANA_ADDR_EXP = {ANA_IDX_EXP[5:0], 2'b00};
  // field positions
  localparam int ANA_BIT_RSVD14 = 14;
  localparam int ANA_BIT_RSVD12 = 12;
  localparam int ANA_BIT_PAGE_RX = 1;
  // selector codes
  localparam logic [4:0] ANA_SEL_8023 = 5'h01;
  localparam logic [4:0] ANA_SEL_ISLAN = 5'h02;
  localparam logic [4:0] ANA_SEL_RSVD_LO = 5'h00;
  localparam logic [4:0] ANA_SEL_RSVD_HI = 5'h1f;
  // last settle count before the strap load, which lands six cycles after reset release
  localparam logic [2:0] ANA_STRAP_SETTLE = 3'h5;
  // axi responses
  localparam logic [1:0] ANA_RESP_OKAY = 2'h0;
  localparam logic [1:0] ANA_RESP_SLVERR = 2'h2;

  // 16-bit ability word, local and partner share the layout
  typedef struct packed {
    logic next_page;
    logic ack;
    logic remote_fault;
    logic rsvd12;
    logic asym_pause;
    logic pause;
    logic t4;
    logic tx_fd;
    logic tx_hd;
    logic t10_fd;
    logic t10_hd;
    logic [4:0] selector;
  } ana_word_t;

  // one register access handed from the bus slave to the register file
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ANA_AW-1:0] waddr;
    logic [ANA_AW-1:0] raddr;
    logic [15:0] wdata;
    logic [1:0] wstrb;
  } ana_req_t;

  localparam ana_word_t ANA_ADV_RST = '{selector: ANA_SEL_8023, default: 1'b0};

  // loader states
  typedef enum logic [1:0] {
    ANA_ST_SETTLE = 2'b01,
    ANA_ST_RUN = 2'b10
  } ana_state_t;
endpackage

// ### tb/ana_lp_model.sv
// link partner model: hands received base pages to the register block
// assumes the negotiation side shares aclk and delivers one page per pulse
`timescale 1ns/1ps
`default_nettype none
module ana_lp_model import ana_pkg::*; (
  // clock
  input wire logic aclk,
  // page delivery
  output logic lp_page_valid,
  output ana_word_t lp_page_word
);
  // idle values at time zero
  initial begin
    lp_page_valid = 1'b0;
    lp_page_word = ana_word_t'(16'h5a5a);
  end

  // one-cycle pulse with the page, then the stale word is scrambled
  task automatic send(input ana_word_t w);
    @(posedge aclk);
    lp_page_valid <= 1'b1;
    lp_page_word <= w;
    @(posedge aclk);
    lp_page_valid <= 1'b0;
    lp_page_word <= ~w; // word no longer held
  endtask
endmodule
`default_nettype wire

// ### tb/ana_regs_tb.sv
// testbench for the auto-negotiation ability registers
// assumes straps static from reset and an axi4-lite master at 25 mhz
`timescale 1ns/1ps
`default_nettype none
module ana_regs_tb import ana_pkg::*;;
  // clock, reset and bus signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_awvalid = 1'b0, s_awready, s_wvalid = 1'b0, s_wready;
  logic [ANA_AW-1:0] s_awaddr = '0, s_araddr = '0;
  logic [31:0] s_wdata = '0, s_rdata;
  logic [3:0] s_wstrb = '0;
  logic s_bvalid, s_bready = 1'b0, s_arvalid = 1'b0, s_arready, s_rvalid, s_rready = 1'b0;
  logic [1:0] s_bresp, s_rresp;
  logic [3:0] config_strap_pins = 4'ha;
  logic pause_strap = 1'b1;
  logic lp_page_valid, page_received;
  ana_word_t lp_page_word, adv_word;
  int n_fail = 0;
  int samples_checked = 0;

  always #20 aclk = ~aclk;

  ana_regs i_ana_regs (.aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_awaddr(s_awaddr), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_araddr(s_araddr), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .config_strap_pins(config_strap_pins),
    .pause_strap(pause_strap), .lp_page_valid(lp_page_valid), .lp_page_word(lp_page_word),
    .adv_word(adv_word), .page_received(page_received));

  ana_lp_model i_ana_lp_model (.aclk(aclk), .lp_page_valid(lp_page_valid), .lp_page_word(lp_page_word));

  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // axi write; handshakes seen at the falling edge act at the next rising edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
    logic ah, wh, b;
    @(posedge aclk);
    s_awvalid <= 1'b1;
    s_awaddr <= a;
    s_wvalid <= 1'b1;
    s_wdata <= d;
    s_wstrb <= st;
    s_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = s_awvalid & s_awready;
      wh = s_wvalid & s_wready;
      b = s_bvalid;
      if (b) chk({30'h0, s_bresp}, {30'h0, er});
      @(posedge aclk);
      if (ah) s_awvalid <= 1'b0;
      if (wh) s_wvalid <= 1'b0;
      if (b) s_bready <= 1'b0;
    end while (!b);
  endtask

  // axi read and compare of data and response
  task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ah, r;
    @(posedge aclk);
    s_arvalid <= 1'b1;
    s_araddr <= a;
    s_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ah = s_arvalid & s_arready;
      r = s_rvalid;
      if (r) chk(s_rdata, exp);
      if (r) chk({30'h0, s_rresp}, {30'h0, er});
      @(posedge aclk);
      if (ah) s_arvalid <= 1'b0;
      if (r) s_rready <= 1'b0;
    end while (!r);
  endtask

  // strap defaults land in the advertisement
  task automatic t_reset_vals();
    axr(ANA_ADDR_ADV, 32'h0000_0541, ANA_RESP_OKAY);
    chk({16'h0, adv_word}, 32'h0000_0541);
  endtask

  // full write, reserved bits dropped, then byte lanes
  task automatic t_adv_write();
    axw(ANA_ADDR_ADV, 32'hffff_ffff, 4'hf, ANA_RESP_OKAY);
    axr(ANA_ADDR_ADV, 32'h0000_afff, ANA_RESP_OKAY);
    chk({16'h0, adv_word}, 32'h0000_afff);
    axw(ANA_ADDR_ADV, {27'h0, ANA_SEL_ISLAN}, 4'h1, ANA_RESP_OKAY);
    axr(ANA_ADDR_ADV, 32'h0000_af02, ANA_RESP_OKAY);
    axw(ANA_ADDR_ADV, {27'h0, ANA_SEL_8023}, 4'h3, ANA_RESP_OKAY);
    axr(ANA_ADDR_ADV, 32'h0000_0001, ANA_RESP_OKAY);
  endtask

  // partner pages and the latching flag, set against clear in one cycle last
  task automatic t_partner();
    i_ana_lp_model.send(ana_word_t'(16'hffff));
    @(negedge aclk);
    chk({31'h0, page_received}, 32'h1);
    axr(ANA_ADDR_LP, 32'h0000_efff, ANA_RESP_OKAY);
    i_ana_lp_model.send(ana_word_t'(16'h4821));
    axr(ANA_ADDR_LP, 32'h0000_4821, ANA_RESP_OKAY);
    axr(ANA_ADDR_EXP, 32'h0000_0002, ANA_RESP_OKAY);
    axr(ANA_ADDR_EXP, 32'h0000_0000, ANA_RESP_OKAY);
    axw(ANA_ADDR_LP, 32'h0000_0000, 4'hf, ANA_RESP_OKAY);
    axr(ANA_ADDR_LP, 32'h0000_4821, ANA_RESP_OKAY);
    fork
      axr(ANA_ADDR_EXP, 32'h0000_0000, ANA_RESP_OKAY);
      i_ana_lp_model.send(ana_word_t'(16'h0001));
    join
    axr(ANA_ADDR_EXP, 32'h0000_0002, ANA_RESP_OKAY);
  endtask

  // unmapped places answer with an error
  task automatic t_unmapped();
    axr(8'h20, 32'h0000_0000, ANA_RESP_SLVERR);
    axw(8'h20, 32'h0000_ffff, 4'hf, ANA_RESP_SLVERR);
    axr(ANA_ADDR_ADV, 32'h0000_0001, ANA_RESP_OKAY);
  endtask

  // mid-run reset with the opposite strap levels; flag and partner word cleared
  task automatic t_restrap();
    i_ana_lp_model.send(ana_word_t'(16'h8421));
    @(posedge aclk);
    aresetn <= 1'b0;
    config_strap_pins <= 4'h5;
    pause_strap <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    chk({31'h0, page_received}, 32'h0);
    chk({16'h0, adv_word}, 32'h0000_00a1);
    axr(ANA_ADDR_ADV, 32'h0000_00a1, ANA_RESP_OKAY);
    axr(ANA_ADDR_LP, 32'h0000_0000, ANA_RESP_OKAY);
  endtask

  // counts and verdict
  task automatic conclude();
    $display("mismatches %0d of %0d comparisons", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    t_reset_vals();
    t_adv_write();
    t_partner();
    t_unmapped();
    t_restrap();
    conclude();
  end

  // watchdog well beyond the expected run of about 120 cycles
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
